/* File: include/scso_pkg.sv */
// constants and types shared by the system clock select blocks
package scso_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] REG_CTRL_ADDR = 16'hff3a;
    localparam logic [15:0] REG_STAT_ADDR = 16'hff3b;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int CTRL_OUT_DIS_BIT = 7;
    localparam int CTRL_SPARE_BIT = 6;
    localparam int SEL_W = 3;
    localparam int CTRL_SEL_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // status register fields
    localparam int STAT_HW_STBY_BIT = 7;
    localparam int STAT_SW_STBY_BIT = 6;
    localparam int STAT_SLEEP_BIT = 5;
    localparam int STAT_BM_EN_BIT = 4;
    localparam int STAT_SEL_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // bus master clock select codes
    localparam logic [2:0] SEL_FULL = 3'h0;
    localparam logic [2:0] SEL_DIV32 = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // medium-speed divider
    localparam int DIV_W = 5;
    localparam int NUM_TAPS = 5;
    localparam logic [4:0] DIV_RESET = 5'h00;
    localparam logic [4:0] DIV_STEP = 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    localparam logic SYNC_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // clock output pin modes
    typedef enum logic [2:0]
    {
        PIN_CLOCK = 3'b001,
        PIN_HIGH = 3'b010,
        PIN_HIZ = 3'b100
    } scso_pin_type;

endpackage : scso_pkg

/* File: rtl/scso_sync.sv */
// three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/1ps

module scso_sync
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // pin in, filtered level out
    input wire logic pin_i,
    output logic level_o
);
    import scso_pkg::*;

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } scso_sync_state_type;

    scso_sync_state_type s_q;
    scso_sync_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.s1 = pin_i;
        // s1 feeds s2 only
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3)
        begin
            s_d.level = s_q.s3;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= {SYNC_RESET, SYNC_RESET, SYNC_RESET, SYNC_RESET};
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.level;

endmodule : scso_sync

/* File: rtl/scso_divider.sv */
// free-running medium-speed divider giving one end-of-period tap per ratio
`timescale 1ns/1ps

module scso_divider
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // tap k is high in the last cycle of each 2^(k+1) period
    output logic [4:0] tap_o
);
    import scso_pkg::*;

    typedef struct packed
    {
        logic [4:0] cnt;
        logic [4:0] tap;
    } scso_div_state_type;

    scso_div_state_type s_q;
    scso_div_state_type s_d;
    logic [4:0] cnt_next;
    logic [4:0] tap_next;

    // never stops, so every ratio is always ready to be picked
    assign cnt_next = s_q.cnt + DIV_STEP;

    genvar k;
    generate
        for (k = 0; k < NUM_TAPS; k = k + 1)
        begin : g_tap
            assign tap_next[k] = &cnt_next[k:0];
        end
    endgenerate

    always_comb
    begin
        s_d = s_q;
        s_d.cnt = cnt_next;
        s_d.tap = tap_next;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= {DIV_RESET, DIV_RESET};
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign tap_o = s_q.tap;

endmodule : scso_divider

/* File: rtl/scso_top.sv */
// system clock select: control register, bus master clock and clock pin
`timescale 1ns/1ps

module scso_top
(
    // clock, reset, freeze
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // register port
    input wire logic [scso_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [scso_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [scso_pkg::DATA_W-1:0] reg_rdata_o,
    // power modes
    input wire logic sleep_i,
    input wire logic sw_standby_i,
    input wire logic hw_standby_b_i,
    // bus master clock
    output logic bm_clk_en_o,
    output logic [scso_pkg::SEL_W-1:0] bm_sel_o,
    // clock output pin
    output logic clk_pin_pass_o,
    output logic clk_pin_o,
    output logic clk_pin_oe_o
);
    import scso_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed
    {
        logic out_dis;
        logic spare;
        logic [2:0] sel;
        logic [2:0] act_sel;
        logic bm_en;
        scso_pin_type pin;
        logic pin_pass;
        logic pin_lvl;
        logic pin_oe;
        logic [7:0] rdata;
    } scso_state_type;

    localparam scso_state_type S_RESET = '{
        out_dis: CTRL_RESET[CTRL_OUT_DIS_BIT],
        spare: CTRL_RESET[CTRL_SPARE_BIT],
        sel: CTRL_RESET[CTRL_SEL_LSB +: SEL_W],
        act_sel: SEL_FULL,
        bm_en: 1'b1,
        pin: PIN_CLOCK,
        pin_pass: 1'b1,
        pin_lvl: 1'b1,
        pin_oe: 1'b1,
        rdata: RDATA_IDLE
    };

    scso_state_type s_q;
    scso_state_type s_d;

    logic [4:0] tap;
    logic hw_stby_b_level;
    logic hw_stby;
    logic wrap;
    logic wr_ctrl;
    logic [2:0] legal_sel;
    logic bm_en_next;
    logic [5:0] rate_pulse;
    logic [7:0] ctrl_word;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    scso_divider u_divider
    (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .tap_o(tap)
    );

    // standby pin is asynchronous to the system clock
    scso_sync u_hw_stby_sync
    (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .pin_i(hw_standby_b_i),
        .level_o(hw_stby_b_level)
    );

    assign hw_stby = ~hw_stby_b_level;

    // every ratio ends its period here, so switching is safe
    assign wrap = tap[NUM_TAPS-1];

    assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // candidate enables, one per defined select code 0 to 5

    // code 0 runs every cycle, code k takes tap k-1
    assign rate_pulse[0] = 1'b1;

    genvar k;
    generate
        for (k = 1; k <= NUM_TAPS; k = k + 1)
        begin : g_rate
            assign rate_pulse[k] = tap[k-1];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control register as software reads it

    always_comb
    begin
        ctrl_word = RDATA_IDLE;
        ctrl_word[CTRL_OUT_DIS_BIT] = s_q.out_dis;
        ctrl_word[CTRL_SPARE_BIT] = s_q.spare;
        ctrl_word[CTRL_SEL_LSB +: SEL_W] = s_q.sel;
        // no storage behind bits 5 to 3
        ctrl_word[5:3] = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // select decode

    always_comb
    begin
        if (s_q.sel > SEL_DIV32)
        begin
            // undefined codes stay at full rate
            legal_sel = SEL_FULL;
        end
        else
        begin
            legal_sel = s_q.sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus master clock enable

    always_comb
    begin
        if (hw_stby || sw_standby_i)
        begin
            // no bus master clock while the chip stands by
            bm_en_next = 1'b0;
        end
        else if (s_q.act_sel == SEL_FULL)
        begin
            bm_en_next = 1'b1;
        end
        else
        begin
            // one pulse at the end of each divided period
            bm_en_next = rate_pulse[s_q.act_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;

        // control register write
        if (wr_ctrl)
        begin
            s_d.out_dis = reg_wdata_i[CTRL_OUT_DIS_BIT];
            s_d.spare = reg_wdata_i[CTRL_SPARE_BIT];
            s_d.sel = reg_wdata_i[CTRL_SEL_LSB +: SEL_W];
            // bits 5 to 3 have no storage
        end

        // software standby leaves the register alone
        if (hw_stby)
        begin
            s_d.out_dis = S_RESET.out_dis;
            s_d.spare = S_RESET.spare;
            s_d.sel = S_RESET.sel;
        end

        // rate change only on the common period boundary, except that hardware standby forces full rate at once
        if (hw_stby)
        begin
            // clock is stopped, nothing to cut short
            s_d.act_sel = SEL_FULL;
        end
        else if (wrap)
        begin
            s_d.act_sel = legal_sel;
        end

        s_d.bm_en = bm_en_next;

        // clock output pin mode
        case (s_q.pin)
            PIN_CLOCK:
            begin
                if (hw_stby)
                begin
                    s_d.pin = PIN_HIZ;
                end
                else if (sw_standby_i || s_d.out_dis)
                begin
                    s_d.pin = PIN_HIGH;
                end
                else
                begin
                    s_d.pin = PIN_CLOCK;
                end
            end
            PIN_HIGH:
            begin
                if (hw_stby)
                begin
                    s_d.pin = PIN_HIZ;
                end
                else if (!sw_standby_i && !s_d.out_dis)
                begin
                    s_d.pin = PIN_CLOCK;
                end
                else
                begin
                    s_d.pin = PIN_HIGH;
                end
            end
            PIN_HIZ:
            begin
                if (hw_stby)
                begin
                    s_d.pin = PIN_HIZ;
                end
                else if (sw_standby_i || s_d.out_dis)
                begin
                    s_d.pin = PIN_HIGH;
                end
                else
                begin
                    s_d.pin = PIN_CLOCK;
                end
            end
            default:
            begin
                s_d.pin = PIN_HIGH;
            end
        endcase

        // pad controls follow the mode in the same edge
        case (s_d.pin)
            PIN_CLOCK:
            begin
                s_d.pin_pass = 1'b1;
                s_d.pin_lvl = 1'b1;
                s_d.pin_oe = 1'b1;
            end
            PIN_HIGH:
            begin
                s_d.pin_pass = 1'b0;
                s_d.pin_lvl = 1'b1;
                s_d.pin_oe = 1'b1;
            end
            PIN_HIZ:
            begin
                s_d.pin_pass = 1'b0;
                s_d.pin_lvl = 1'b1;
                s_d.pin_oe = 1'b0;
            end
            default:
            begin
                s_d.pin_pass = 1'b0;
                s_d.pin_lvl = 1'b1;
                s_d.pin_oe = 1'b1;
            end
        endcase

        // read data stands for exactly one cycle
        s_d.rdata = RDATA_IDLE;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                REG_CTRL_ADDR:
                begin
                    s_d.rdata = ctrl_word;
                end
                REG_STAT_ADDR:
                begin
                    s_d.rdata[STAT_HW_STBY_BIT] = hw_stby;
                    s_d.rdata[STAT_SW_STBY_BIT] = sw_standby_i;
                    s_d.rdata[STAT_SLEEP_BIT] = sleep_i;
                    s_d.rdata[STAT_BM_EN_BIT] = s_q.bm_en;
                    s_d.rdata[STAT_SEL_LSB +: SEL_W] = s_q.act_sel;
                end
                default:
                begin
                    // unmapped reads return zero
                    s_d.rdata = RDATA_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= S_RESET;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign reg_rdata_o = s_q.rdata;
    assign bm_clk_en_o = s_q.bm_en;
    assign bm_sel_o = s_q.act_sel;
    assign clk_pin_pass_o = s_q.pin_pass;
    assign clk_pin_o = s_q.pin_lvl;
    assign clk_pin_oe_o = s_q.pin_oe;

endmodule : scso_top

/* File: tb/scso_checker.sv */
// port assertions for the system clock select block
`timescale 1ns/1ps

module scso_checker
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // register read
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_rdata_o,
    // power modes
    input wire logic sw_standby_i,
    input wire logic hw_standby_b_i,
    // outputs
    input wire logic bm_clk_en_o,
    input wire logic [2:0] bm_sel_o,
    input wire logic clk_pin_pass_o,
    input wire logic clk_pin_o,
    input wire logic clk_pin_oe_o
);
    logic [5:0] gap_q;
    logic [2:0] prev_q;
    logic seen_q;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////
    // gap since last pulse; first pulse after a rate change or standby is not judged
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            gap_q <= 6'h00;
            prev_q <= 3'h0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q <= bm_clk_en_o ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3f};
            prev_q <= bm_sel_o;
            seen_q <= bm_sel_o == prev_q && !sw_standby_i && hw_standby_b_i
                && (seen_q || bm_clk_en_o);
        end
    end

    ////////////////////////////////////////
    rd_reserved_a: assert property (
        reg_rd_i && reg_addr_i == 16'hff3a |=> reg_rdata_o[5:3] == 3'h0)
        else $error("reserved bits read nonzero");
    sel_legal_a: assert property (bm_sel_o <= 3'h5)
        else $error("undefined rate applied");
    full_rate_a: assert property (
        (bm_sel_o == 3'h0 && !sw_standby_i && hw_standby_b_i)[*8] |-> bm_clk_en_o)
        else $error("full rate enable dropped");
    div_period_a: assert property (
        bm_clk_en_o && seen_q && bm_sel_o == prev_q && bm_sel_o != 3'h0
        |-> gap_q == (6'h01 << bm_sel_o) - 6'h01)
        else $error("divided period wrong");
    sel_hold_a: assert property (
        $changed(bm_sel_o) && hw_standby_b_i |=> $stable(bm_sel_o)[*8])
        else $error("rate switched off boundary");
    sw_pin_a: assert property (
        (sw_standby_i && hw_standby_b_i)[*8] |-> !clk_pin_pass_o && clk_pin_o && clk_pin_oe_o)
        else $error("pin not high in soft standby");
    hw_hiz_a: assert property (
        (!hw_standby_b_i)[*8] |-> !clk_pin_oe_o && !clk_pin_pass_o && bm_sel_o == 3'h0)
        else $error("pin not released in hard standby");
    pass_cause_a: assert property (clk_pin_pass_o |-> clk_pin_oe_o && !$past(sw_standby_i))
        else $error("clock passed without cause");

    cover property (bm_sel_o == 3'h5 && bm_clk_en_o);
    cover property (!clk_pin_oe_o);
    cover property (sw_standby_i && !clk_pin_pass_o);
endmodule : scso_checker

bind scso_top scso_checker chk_i
(
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_rdata_o(reg_rdata_o),
    .sw_standby_i(sw_standby_i),
    .hw_standby_b_i(hw_standby_b_i),
    .bm_clk_en_o(bm_clk_en_o),
    .bm_sel_o(bm_sel_o),
    .clk_pin_pass_o(clk_pin_pass_o),
    .clk_pin_o(clk_pin_o),
    .clk_pin_oe_o(clk_pin_oe_o)
);

/* File: tb/scso_bm_model.sv */
// bus master model counting the clock enable pulses it receives
`timescale 1ns/1ps

module scso_bm_model
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // enable in, states run out
    input wire logic bm_clk_en_i,
    output logic [15:0] ticks_o
);
    // advances only on a granted enable, like a stalled core
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            ticks_o <= 16'h0000;
        else if (bm_clk_en_i)
            ticks_o <= ticks_o + 16'h0001;
    end
endmodule : scso_bm_model

/* File: tb/tb_top.sv */
// self-checking bench for the system clock select block
`timescale 1ns/1ps

module tb_top;
    import scso_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic sw_standby_i = 1'b0;
    logic hw_standby_b_i = 1'b1;
    logic [7:0] reg_rdata_o;
    logic bm_clk_en_o;
    logic [2:0] bm_sel_o;
    logic clk_pin_pass_o, clk_pin_o, clk_pin_oe_o;
    logic [15:0] ticks;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;

    scso_top dut
    (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(1'b1),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .sleep_i(sleep_i),
        .sw_standby_i(sw_standby_i),
        .hw_standby_b_i(hw_standby_b_i),
        .bm_clk_en_o(bm_clk_en_o),
        .bm_sel_o(bm_sel_o),
        .clk_pin_pass_o(clk_pin_pass_o),
        .clk_pin_o(clk_pin_o),
        .clk_pin_oe_o(clk_pin_oe_o)
    );
    scso_bm_model bm (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bm_clk_en_i(bm_clk_en_o),
        .ticks_o(ticks));

    always #50 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    // undefined codes fall back to full rate
    function automatic logic [2:0] eff(input logic [2:0] c);
        return (c > 3'h5) ? 3'h0 : c;
    endfunction : eff

    task automatic close_out();
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("wrong value %s exp %h got %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("rdata", e, reg_rdata_o);
    endtask : rchk

    // pass, level, enable of the clock pin after n cycles
    task automatic pins(input int n, input logic [2:0] e);
        repeat (n) @(negedge clk_sys_i);
        chk("pin", {5'h00, e}, {5'h00, clk_pin_pass_o, clk_pin_o, clk_pin_oe_o});
    endtask : pins

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            close_out();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        logic [15:0] t0;
        logic [7:0] v;
        r = 32'h0858;
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rchk(REG_CTRL_ADDR, CTRL_RESET);
        // software keeps bit 6 zero
        repeat (12)
        begin
            r = lfsr(r);
            v = r[7:0] & 8'hbf;
            wr(REG_CTRL_ADDR, v);
            rchk(REG_CTRL_ADDR, v & 8'hc7);
        end
        wr(REG_CTRL_ADDR, 8'h40);
        wr(16'hff3c, 8'hff);
        rchk(16'hff3c, 8'h00);
        rchk(REG_CTRL_ADDR, 8'h40);
        for (int c = 0; c < 8; c++)
        begin
            wr(REG_CTRL_ADDR, {5'h00, c[2:0]});
            repeat (36) @(negedge clk_sys_i);
            chk("sel", {5'h00, eff(c[2:0])}, {5'h00, bm_sel_o});
            t0 = ticks;
            repeat (64) @(negedge clk_sys_i);
            chk("ticks", 8'h40 >> eff(c[2:0]), 8'(ticks - t0));
        end
        @(posedge clk_sys_i);
        sleep_i <= 1'b1;
        pins(3, 3'b111);
        rchk(REG_STAT_ADDR, 8'h30);
        wr(REG_CTRL_ADDR, 8'h85);
        pins(2, 3'b011);
        @(posedge clk_sys_i);
        sleep_i <= 1'b0;
        sw_standby_i <= 1'b1;
        wr(REG_CTRL_ADDR, 8'h05);
        pins(10, 3'b011);
        chk("en", 8'h00, {7'h00, bm_clk_en_o});
        rchk(REG_CTRL_ADDR, 8'h05);
        @(posedge clk_sys_i);
        sw_standby_i <= 1'b0;
        pins(40, 3'b111);
        @(posedge clk_sys_i);
        hw_standby_b_i <= 1'b0;
        pins(10, 3'b010);
        @(posedge clk_sys_i);
        hw_standby_b_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rchk(REG_CTRL_ADDR, 8'h00);
        close_out();
    end
endmodule : tb_top
